/* File: baud_gen.sv */
`include "uart_ready_params.svh"
`default_nettype none
module baud_gen
   import uart_ready_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              prescale_div4,
   input  wire uart_ready_pkg::divisor_t divisor,
   output logic                   sample_tick
);
   typedef struct packed {
      logic [1:0] pre_cnt;
      divisor_t   div_cnt;
      logic       tick;
   } bg_state_t;

   bg_state_t s_r;
   bg_state_t s_nxt;
   logic      pre_tick;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      // Prescaler: every cycle when dividing by one, else one in four.
      pre_tick = 1'b0;
      if (prescale_div4) begin
         s_nxt.pre_cnt = s_r.pre_cnt + 2'd1;
         pre_tick = (s_r.pre_cnt == 2'(`PRESCALE_RATIO - 1));
      end else begin
         s_nxt.pre_cnt = 2'd0;
         pre_tick = 1'b1;
      end
      // Divisor counter; a zero divisor is treated as one.
      if (pre_tick) begin
         if (s_r.div_cnt <= 16'h0001) begin
            s_nxt.div_cnt = divisor;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.div_cnt = s_r.div_cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sample_tick = s_r.tick;
endmodule
`default_nettype wire

/* File: host_reader.sv */
`default_nettype none
// Host that reads one byte each time it sees the receive ready pin low.
module host_reader (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic ready_n,
   input  wire logic en,
   output logic      rd
);
   timeunit 1ns;
   timeprecision 100ps;
   always_ff @(posedge mclk or negedge reset_n)
      if (!reset_n) rd <= 1'b0;
      else rd <= en && !ready_n && !rd;
endmodule
`default_nettype wire

/* File: rx_timeout.sv */
`include "uart_ready_params.svh"
`default_nettype none
module rx_timeout
   import uart_ready_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              sample_tick,
   input  wire uart_ready_pkg::word_len_t word_len,
   input  wire logic              rx_fifo_nonempty,
   input  wire logic              rx_char_done,
   input  wire logic              rx_read,
   output logic                   timeout
);
   typedef struct packed {
      logic [12:0] cnt;
      logic        hit;
   } to_state_t;

   to_state_t   s_r;
   to_state_t   s_nxt;
   logic [12:0] limit;

   always_comb begin
      // Four characters of data plus framing, plus twelve bit times, in samples.
      limit = 13'((`TIMEOUT_CHARS * (5 + word_len + `FRAME_OVERHEAD)
                   + `TIMEOUT_EXTRA_BITS) * `SAMPLES_PER_BIT);
      s_nxt = s_r;
      if (!rx_fifo_nonempty || rx_char_done || rx_read) begin
         s_nxt.cnt = '0;
         s_nxt.hit = 1'b0;
      end else if (sample_tick && !s_r.hit) begin
         s_nxt.cnt = s_r.cnt + 13'd1;
         s_nxt.hit = (s_r.cnt + 13'd1 >= limit);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign timeout = s_r.hit;
endmodule
`default_nettype wire

/* File: uart_ready_assertions.sv */
`default_nettype none
module uart_ready_assertions
   import uart_ready_pkg::*;
(
   input wire logic                        mclk,
   input wire logic                        reset_n,
   input wire logic                        fifo_enable,
   input wire logic                        block_mode,
   input wire logic                        tx_int_select,
   input wire logic                        prescale_wr,
   input wire logic                        thr_full,
   input wire logic                        tsr_empty,
   input wire uart_ready_pkg::fifo_level_t tx_fifo_level,
   input wire logic                        tx_fifo_full_flag,
   input wire uart_ready_pkg::fifo_level_t rx_fifo_level,
   input wire uart_ready_pkg::fifo_level_t rx_trigger,
   input wire logic                        tx_int,
   input wire logic                        tx_ready_n,
   input wire logic                        rx_ready_n,
   input wire logic                        prescale_state
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_txint_hold: assert property (
      !fifo_enable && !tx_int_select |=> tx_int == !$past(thr_full)) else $error("tx_int");
   a_txint_shift: assert property (
      tx_int_select && !tsr_empty |=> !tx_int) else $error("tx_int shift");
   a_tx_ready_n_single: assert property (
      fifo_enable && !block_mode |=> tx_ready_n == ($past(tx_fifo_level) != 8'h00))
      else $error("tx_ready_n single");
   a_rx_ready_n_single: assert property (
      fifo_enable && !block_mode |=> rx_ready_n == ($past(rx_fifo_level) == 8'h00))
      else $error("rx_ready_n single");
   a_tx_ready_n_block: assert property (
      fifo_enable && block_mode |=> tx_ready_n ==
      ($past(tx_fifo_full_flag) || $past(tx_fifo_level) >= 8'h80)) else $error("tx_ready_n");
   a_rx_ready_n_trig: assert property (
      fifo_enable && block_mode && rx_fifo_level != 8'h00 && rx_fifo_level >= rx_trigger
      |=> !rx_ready_n) else $error("rx_ready_n trigger");
   a_rx_ready_n_empty: assert property (
      fifo_enable && block_mode && rx_fifo_level == 8'h00 |=> rx_ready_n)
      else $error("rx_ready_n empty");
   a_presc_load: assert property (
      $rose(prescale_state) |-> $past(prescale_wr)) else $error("prescale");
endmodule
bind uart_ready_int uart_ready_assertions u_chk (.mclk, .reset_n, .fifo_enable, .block_mode,
   .tx_int_select, .prescale_wr, .thr_full, .tsr_empty, .tx_fifo_level, .tx_fifo_full_flag,
   .rx_fifo_level, .rx_trigger, .tx_int, .tx_ready_n, .rx_ready_n, .prescale_state);
`default_nettype wire

/* File: uart_ready_int.sv */
`include "uart_ready_params.svh"
`default_nettype none
module uart_ready_int
   import uart_ready_pkg::*;
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
)(
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              fifo_enable,
   input  wire logic              block_mode,
   input  wire logic              tx_int_select,
   input  wire logic              prescale_wr,
   input  wire logic              prescale_bit,
   input  wire logic [7:0]        divisor_high_byte,
   input  wire logic [7:0]        divisor_low_byte,
   input  wire uart_ready_pkg::word_len_t word_len,
   input  wire logic              thr_full,
   input  wire logic              tsr_empty,
   input  wire uart_ready_pkg::fifo_level_t tx_fifo_level,
   input  wire logic              tx_fifo_full_flag,
   input  wire uart_ready_pkg::fifo_level_t tx_trigger,
   input  wire logic              rhr_full,
   input  wire uart_ready_pkg::fifo_level_t rx_fifo_level,
   input  wire uart_ready_pkg::fifo_level_t rx_trigger,
   input  wire logic              rx_char_done,
   input  wire logic              rx_read,
   output logic                   tx_int,
   output logic                   rx_int,
   output logic                   tx_ready_n,
   output logic                   rx_ready_n,
   output logic                   sample_tick,
   output logic                   bit_tick,
   output logic                   prescale_state
);
   typedef struct packed {
      logic       prescale;
      logic [3:0] sample_cnt;
      logic       bit_tick;
      logic       rx_block_low;
      logic       tx_int;
      logic       rx_int;
      logic       tx_ready_n;
      logic       rx_ready_n;
   } top_state_t;

   top_state_t s_r;
   top_state_t s_nxt;
   divisor_t   divisor;
   logic       timeout;
   logic       tx_empty;
   logic       rx_empty;
   logic       tx_full;
   logic       tx_int_src;

   assign divisor = {divisor_high_byte, divisor_low_byte};

   // Each channel instantiates its own copy of this block, hence its own
   // generator; all run from mclk, and the host registers are plain ports except the prescaler bit, held here.
   baud_gen u_baud (
      .mclk          (mclk),
      .reset_n       (reset_n),
      .prescale_div4 (s_r.prescale),
      .divisor       (divisor),
      .sample_tick   (sample_tick)
   );

   rx_timeout u_timeout (
      .mclk             (mclk),
      .reset_n          (reset_n),
      .sample_tick      (sample_tick),
      .word_len         (word_len),
      .rx_fifo_nonempty (fifo_enable && rx_fifo_level != '0),
      .rx_char_done     (rx_char_done),
      .rx_read          (rx_read),
      .timeout          (timeout)
   );

   always_comb begin
      s_nxt = s_r;
      tx_empty = (tx_fifo_level == '0);
      rx_empty = (rx_fifo_level == '0);
      tx_full  = tx_fifo_full_flag || (32'(tx_fifo_level) >= FIFO_DEPTH);
      if (prescale_wr) begin
         s_nxt.prescale = prescale_bit;
      end
      // The shifter and sampler count sixteen ticks per bit.
      s_nxt.bit_tick = 1'b0;
      if (sample_tick) begin
         s_nxt.sample_cnt = s_r.sample_cnt + 4'd1;
         s_nxt.bit_tick = (s_r.sample_cnt == 4'(`SAMPLES_PER_BIT - 1));
      end
      // Transmit interrupt.
      if (!fifo_enable) begin
         tx_int_src = !thr_full;
      end else begin
         tx_int_src = (tx_fifo_level <= tx_trigger) || tx_empty;
      end
      if (tx_int_select) begin
         s_nxt.tx_int = tx_int_src && tsr_empty && (fifo_enable ? tx_empty : !thr_full);
      end else begin
         s_nxt.tx_int = tx_int_src;
      end
      // Receive interrupt.
      if (!fifo_enable) begin
         s_nxt.rx_int = rhr_full;
      end else if (block_mode) begin
         s_nxt.rx_int = (rx_fifo_level >= rx_trigger);
      end else begin
         s_nxt.rx_int = !rx_empty;
      end
      // Block-mode receive ready latch: set at trigger or timeout, clear on empty.
      if (rx_empty) begin
         s_nxt.rx_block_low = 1'b0;
      end else if ((rx_fifo_level >= rx_trigger) || timeout) begin
         s_nxt.rx_block_low = 1'b1;
      end
      // Ready pins, mode picked by the FIFO-enable and block-mode bits.
      if (!fifo_enable) begin
         s_nxt.rx_ready_n = !rhr_full;
         s_nxt.tx_ready_n = thr_full;
      end else if (block_mode) begin
         s_nxt.rx_ready_n = !s_nxt.rx_block_low;
         s_nxt.tx_ready_n = tx_full;
      end else begin
         s_nxt.rx_ready_n = rx_empty;
         s_nxt.tx_ready_n = !tx_empty;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.prescale <= `PRESCALE_RESET;
         s_r.tx_ready_n <= 1'b0;
         s_r.rx_ready_n <= 1'b1;
         s_r.tx_int <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tx_int         = s_r.tx_int;
   assign rx_int         = s_r.rx_int;
   assign tx_ready_n     = s_r.tx_ready_n;
   assign rx_ready_n     = s_r.rx_ready_n;
   assign bit_tick       = s_r.bit_tick;
   assign prescale_state = s_r.prescale;
endmodule
`default_nettype wire

/* File: uart_ready_int_bench.sv */
`default_nettype none
module uart_ready_int_bench
   import uart_ready_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 0, reset_n = 0, fifo_enable = 0, block_mode = 0, tx_int_select = 0;
   logic prescale_wr = 0, prescale_bit = 0, thr_full = 0, tsr_empty = 1, tx_fifo_full_flag = 0;
   logic rhr_full = 0, rx_char_done = 0, rx_read, read_en = 0;
   logic tx_int, rx_int, tx_ready_n, rx_ready_n, sample_tick, bit_tick, prescale_state;
   logic [7:0] divisor_high_byte = 0, divisor_low_byte = 8'h01;
   word_len_t word_len = 0;
   fifo_level_t tx_fifo_level = 0, tx_trigger = 0, rx_fifo_level = 0, rx_trigger = 0;
   int errors = 0, n_tests = 0, cyc = 0, n, i, dv;
   always #12.5 mclk = ~mclk;
   uart_ready_int dut (.mclk, .reset_n, .fifo_enable, .block_mode, .tx_int_select, .prescale_wr,
      .prescale_bit, .divisor_high_byte, .divisor_low_byte, .word_len, .thr_full, .tsr_empty,
      .tx_fifo_level, .tx_fifo_full_flag, .tx_trigger, .rhr_full, .rx_fifo_level, .rx_trigger,
      .rx_char_done, .rx_read, .tx_int, .rx_int, .tx_ready_n, .rx_ready_n, .sample_tick,
      .bit_tick, .prescale_state);
   host_reader host (.mclk, .reset_n, .ready_n(rx_ready_n), .en(read_en), .rd(rx_read));
   task stop_test();
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         stop_test();
      end
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   function automatic logic exp_tx_rdy();
      if (!fifo_enable) return thr_full;
      if (!block_mode) return tx_fifo_level != 8'h00;
      return tx_fifo_full_flag || tx_fifo_level >= 8'h80;
   endfunction
   function automatic logic exp_tx_int();
      if (tx_int_select) return tsr_empty && (fifo_enable ? tx_fifo_level == 8'h00 : !thr_full);
      if (!fifo_enable) return !thr_full;
      return tx_fifo_level < tx_trigger || tx_fifo_level == 8'h00;
   endfunction
   function automatic logic exp_rx_int();
      if (!fifo_enable) return rhr_full;
      if (block_mode) return rx_fifo_level >= rx_trigger;
      return rx_fifo_level != 8'h00;
   endfunction
   // Measures the cycles from one tick to the next.
   task gap(input bit b, output int k);
      int t;
      t = 0;
      k = 0;
      while ((b ? bit_tick : sample_tick) !== 1'b1 && t < 20000) begin
         @(posedge mclk);
         #1 t++;
      end
      do begin
         @(posedge mclk);
         #1 k++;
      end while ((b ? bit_tick : sample_tick) !== 1'b1 && k < 20000);
   endtask
   initial begin
      void'($urandom(32'head3));
      repeat (8) @(posedge mclk);
      #2 reset_n = 1;
      check("prescale_state", prescale_state, 1'b0);
      read_en = 1;
      for (i = 0; i < 400; i++) begin
         @(posedge mclk);
         #2;
         {fifo_enable, block_mode, tx_int_select, thr_full, tsr_empty, rhr_full} = 6'($urandom);
         tx_fifo_level = ($urandom % 4 == 0) ? 8'(126 + $urandom % 4) : 8'($urandom % 3);
         tx_fifo_full_flag = ($urandom % 8 == 0);
         tx_trigger = 8'($urandom % 3);
         rx_fifo_level = 8'($urandom % 3);
         rx_trigger = 8'($urandom % 3);
         rx_char_done = 1'($urandom);
         @(posedge mclk);
         #1;
         check("tx_ready_n", tx_ready_n, exp_tx_rdy());
         if (!fifo_enable || !block_mode)
            check("rx_ready_n", rx_ready_n, fifo_enable ? rx_fifo_level == 0 : !rhr_full);
         if (tx_int_select || !fifo_enable || tx_fifo_level != tx_trigger)
            check("tx_int", tx_int, exp_tx_int());
         check("rx_int", rx_int, exp_rx_int());
      end
      // Timeout at the shortest and the longest word length.
      for (i = 0; i < 2; i++) begin
         @(posedge mclk);
         #2;
         {read_en, rx_char_done, fifo_enable, block_mode, rx_fifo_level} = {4'b0011, 8'h00};
         rx_trigger = 8'h08;
         word_len = 2'(i * 3);
         @(posedge mclk);
         #2 rx_fifo_level = 8'h01;
         rx_char_done = 1;
         @(posedge mclk);
         #2 rx_char_done = 0;
         n = 0;
         while (rx_ready_n !== 1'b0 && n < 2000) begin
            @(posedge mclk);
            #1 n++;
         end
         dv = (4 * (5 + i * 3 + 4) + 12) * 16;
         check("timeout", n >= dv - 8 && n <= dv + 8, 1);
      end
      for (i = 0; i < 3; i++) begin
         @(posedge mclk);
         #2 prescale_bit = i[0];
         prescale_wr = 1;
         dv = i[1] * 256 + i * 3 + 1;
         {divisor_high_byte, divisor_low_byte} = 16'(dv);
         @(posedge mclk);
         #2 prescale_wr = 0;
         gap(0, n);
         gap(0, n);
         check("prescale_state", prescale_state, i[0]);
         check("sample period", n, dv * (i[0] ? 4 : 1));
         gap(1, n);
         gap(1, n);
         check("bit period", n, 16 * dv * (i[0] ? 4 : 1));
      end
      stop_test();
   end
endmodule
`default_nettype wire

/* File: uart_ready_params.svh */
`ifndef UART_READY_PARAMS_SVH
`define UART_READY_PARAMS_SVH

// Prescaler ratio applied when the prescaler bit is set.
`define PRESCALE_RATIO      4
// Sampling clock periods per serial bit.
`define SAMPLES_PER_BIT     16
// Transmit and receive FIFO depth in bytes.
`define FIFO_DEPTH          128
// Extra bit times added to four character lengths for the receive timeout.
`define TIMEOUT_EXTRA_BITS  12
// Character lengths counted by the receive timeout.
`define TIMEOUT_CHARS       4
// Reset value of the prescaler bit.
`define PRESCALE_RESET      1'b0
// Reset value of the divisor.
`define DIVISOR_RESET       16'h0001
// Bits of a character besides its data bits: start, parity and stop at most.
`define FRAME_OVERHEAD      4

`endif

/* File: uart_ready_pkg.sv */
`default_nettype none
package uart_ready_pkg;
   typedef logic [15:0] divisor_t;
   typedef logic [7:0]  fifo_level_t;
   typedef logic [1:0]  word_len_t;
endpackage
`default_nettype wire
